// [core/pwm_timer_consts.vh]
// Register map, field positions and reset values of the match-based PWM timer
`ifndef PWM_TIMER_CONSTS_VH
`define PWM_TIMER_CONSTS_VH

`define OFF_STATUS    8'h00
`define OFF_CTRL      8'h04
`define OFF_COUNT     8'h08
`define OFF_PRESCALE  8'h0C
`define OFF_PCOUNT    8'h10
`define OFF_ACTION    8'h14
`define OFF_MATCH0    8'h18
`define OFF_MATCH6    8'h30
`define OFF_OUTCFG    8'h34
`define OFF_RELEASE   8'h38
`define OFF_MASK      8'h3C

`define CTRL_RUN      0
`define CTRL_CLEAR    1
`define CTRL_PWM      3
`define CTRL_W        4
`define CTRL_RST      4'h0
`define CTRL_WMASK    4'hB

`define MIDX_HI       4
`define MIDX_LO       2

`define ACT_INT       0
`define ACT_RESET     1
`define ACT_STOP      2
`define ACT_W         3

`define OUTCFG_EN_LSB 9
`define OUTCFG_W      15
`define OUTCFG_RST    15'h0000

`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`define ZERO32        32'h00000000
`define ONE32         32'h00000001

`endif

// [core/match_unit.v]
// One match channel: active compare value, loaded from its shadow, and the compare itself
`timescale 1ns/1ns
module match_unit #(
  parameter W = 32
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         load_i,
  input  wire [W-1:0] shadow_i,
  input  wire [W-1:0] count_i,
  input  wire         tick_i,
  output wire         hit_o
);

  reg [W-1:0] active_q;

  // Compare only on a counter advance so each count position matches once
  assign hit_o = tick_i && (count_i == active_q);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_q <= {W{1'b0}};
    end else if (load_i) begin
      active_q <= shadow_i;
    end
  end

endmodule // match_unit

// [core/pwm_timer.v]
// Match-based PWM timer with prescaler, seven match channels and an AXI4-Lite register slave
// How it works
// RQ1: 32-bit counter advanced through programmable prescaler
// RQ2: seven matches drive six single or three double
// RQ3: cycle-period match resets the count
// RQ4: single-edge outputs rise at period match
// RQ5: own match sets single-edge falling position
// RQ6: two matches set rise and fall edges
// RQ7: double edges sit at any count
// RQ8: period and width any count, shared rate
// RQ9: per match: continue, stop, reset, optional interrupt
// RQ10: match values apply only after software release
// RQ11: without PWM mode behave as plain timer
// RQ12: released values load at next period match
// RQ13: count advances when prescaler hits limit, restarts
`timescale 1ns/1ns
`include "pwm_timer_consts.vh"
module pwm_timer #(
  parameter W      = 32,
  parameter NMATCH = 7,
  parameter NOUT   = 6
) (
  input  wire            clk_i,
  input  wire            rst_i,
  input  wire [7:0]      awaddr_i,
  input  wire            awvalid_i,
  output reg             awready_o,
  input  wire [31:0]     wdata_i,
  input  wire [3:0]      wstrb_i,
  input  wire            wvalid_i,
  output reg             wready_o,
  output reg  [1:0]      bresp_o,
  output reg             bvalid_o,
  input  wire            bready_i,
  input  wire [7:0]      araddr_i,
  input  wire            arvalid_i,
  output reg             arready_o,
  output reg  [31:0]     rdata_o,
  output reg  [1:0]      rresp_o,
  output reg             rvalid_o,
  input  wire            rready_i,
  output reg  [NOUT-1:0] pwm_o,
  output reg             irq_o
);

  localparam AW = NMATCH * `ACT_W;

  reg  [W-1:0]          count_q;
  reg  [W-1:0]          pcount_q;
  reg  [W-1:0]          prescale_q;
  reg  [`CTRL_W-1:0]    ctrl_q;
  reg  [AW-1:0]         action_q;
  reg  [`OUTCFG_W-1:0]  outcfg_q;
  reg  [NMATCH-1:0]     release_q;
  reg  [NMATCH-1:0]     status_q;
  reg  [NMATCH-1:0]     mask_q;
  reg  [NOUT:1]         level_q;
  reg  [W-1:0]          shadow_q [0:NMATCH-1];

  reg  [7:0]            awaddr_q;
  reg  [31:0]           wdata_q;
  reg  [3:0]            wstrb_q;

  wire                  run;
  wire                  pwm_en;
  wire                  tick;
  wire [NMATCH-1:0]     hit;
  wire [NMATCH-1:0]     load;
  wire                  period_ev;
  wire                  do_write;
  wire [31:0]           ctrl_m;
  wire [31:0]           action_m;
  wire [31:0]           outcfg_m;
  wire [NMATCH-1:0]     release_clr;

  reg  [NMATCH-1:0]     act_int;
  reg  [NMATCH-1:0]     act_reset;
  reg  [NMATCH-1:0]     act_stop;
  reg                   reset_hit;
  reg                   stop_hit;
  reg  [NMATCH-1:0]     status_d;
  reg  [NOUT:1]         level_d;
  reg  [NOUT-1:0]       pwm_d;
  reg  [31:0]           rd_val;
  reg                   rd_ok;
  reg                   wr_ok;
  reg  [NMATCH-1:0]     w1c;
  reg  [2:0]            mr_rd_idx;
  reg  [2:0]            mr_wr_idx;
  reg  [7:0]            rd_off;
  reg  [7:0]            wr_off;
  reg  [7:0]            mr_rd_off;
  reg  [7:0]            mr_wr_off;
  integer               i;
  integer               j;
  integer               k;
  genvar                g;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  assign run       = ctrl_q[`CTRL_RUN] && !ctrl_q[`CTRL_CLEAR];
  assign pwm_en    = ctrl_q[`CTRL_PWM];
  assign tick      = run && (pcount_q == prescale_q); // RQ13
  assign period_ev = pwm_en && hit[0];
  assign do_write  = !awready_o && !wready_o && !bvalid_o;

  // Byte lanes merge at full word width, then narrow registers keep only their bits
  assign ctrl_m      = merge({{(32-`CTRL_W){1'b0}}, ctrl_q}, wdata_q, wstrb_q);
  assign action_m    = merge({{(32-AW){1'b0}}, action_q}, wdata_q, wstrb_q);
  assign outcfg_m    = merge({{(32-`OUTCFG_W){1'b0}}, outcfg_q}, wdata_q, wstrb_q);
  assign release_clr = period_ev ? load : {NMATCH{1'b0}};

  // Plain timer follows the written value at once; PWM mode waits for release and period
  generate
    for (g = 0; g < NMATCH; g = g + 1) begin : g_match
      assign load[g] = !pwm_en || (period_ev && release_q[g]); // RQ10 RQ11 RQ12
      match_unit #(
        .W (W)
      ) u_match (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (load[g]),
        .shadow_i (shadow_q[g]),
        .count_i  (count_q),
        .tick_i   (tick),
        .hit_o    (hit[g])
      );
    end
  endgenerate

  // Match actions and interrupt events
  always @* begin
    for (i = 0; i < NMATCH; i = i + 1) begin
      act_int[i]   = action_q[i*`ACT_W + `ACT_INT];
      act_reset[i] = action_q[i*`ACT_W + `ACT_RESET];
      act_stop[i]  = action_q[i*`ACT_W + `ACT_STOP];
    end
    reset_hit = |(hit & act_reset) || period_ev; // RQ3 RQ9
    stop_hit  = |(hit & act_stop); // RQ9
    w1c = {NMATCH{1'b0}};
    if (do_write && wr_off == `OFF_STATUS) begin
      w1c = wdata_q[NMATCH-1:0];
    end
    // A match in the clearing cycle stays pending
    status_d = (status_q & ~w1c) | (hit & act_int); // RQ9
  end

  // Output edges; a fall and a rise in one cycle leave the output low
  // Channel 1 has no lower partner match, so it is always single-edge
  always @* begin
    for (j = 1; j <= NOUT; j = j + 1) begin
      level_d[j] = level_q[j];
      if (j >= 2 && outcfg_q[j]) begin
        if (hit[j-1]) begin
          level_d[j] = 1'b1; // RQ6 RQ7
        end
      end else if (hit[0]) begin
        level_d[j] = 1'b1; // RQ4
      end
      if (hit[j]) begin
        level_d[j] = 1'b0; // RQ5 RQ6 RQ8
      end
      pwm_d[j-1] = pwm_en && outcfg_q[`OUTCFG_EN_LSB + j - 1] && level_d[j]; // RQ2 RQ11
    end
  end

  // Read decode
  always @* begin
    rd_off    = araddr_i;
    mr_rd_off = araddr_i - `OFF_MATCH0;
    mr_rd_idx = 3'h0;
    rd_val    = `ZERO32;
    rd_ok     = 1'b1;
    if (rd_off[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (rd_off >= `OFF_MATCH0 && rd_off <= `OFF_MATCH6) begin
      mr_rd_idx = mr_rd_off[`MIDX_HI:`MIDX_LO];
      rd_val    = shadow_q[mr_rd_idx];
    end else begin
      case (rd_off)
        `OFF_STATUS:   rd_val[NMATCH-1:0]     = status_q;
        `OFF_CTRL:     rd_val[`CTRL_W-1:0]    = ctrl_q;
        `OFF_COUNT:    rd_val                 = count_q;
        `OFF_PRESCALE: rd_val                 = prescale_q;
        `OFF_PCOUNT:   rd_val                 = pcount_q;
        `OFF_ACTION:   rd_val[AW-1:0]         = action_q;
        `OFF_OUTCFG:   rd_val[`OUTCFG_W-1:0]  = outcfg_q;
        `OFF_RELEASE:  rd_val[NMATCH-1:0]     = release_q;
        `OFF_MASK:     rd_val[NMATCH-1:0]     = mask_q;
        default:       rd_ok                  = 1'b0;
      endcase
    end
  end

  // Write decode
  always @* begin
    wr_off    = awaddr_q;
    mr_wr_off = awaddr_q - `OFF_MATCH0;
    mr_wr_idx = 3'h0;
    wr_ok     = 1'b1;
    if (wr_off[1:0] != 2'h0) begin
      wr_ok = 1'b0;
    end else if (wr_off >= `OFF_MATCH0 && wr_off <= `OFF_MATCH6) begin
      mr_wr_idx = mr_wr_off[`MIDX_HI:`MIDX_LO];
    end else begin
      case (wr_off)
        `OFF_STATUS, `OFF_CTRL, `OFF_COUNT, `OFF_PRESCALE, `OFF_PCOUNT,
        `OFF_ACTION, `OFF_OUTCFG, `OFF_RELEASE, `OFF_MASK: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_o  <= 1'b1;
      wready_o   <= 1'b1;
      bvalid_o   <= 1'b0;
      bresp_o    <= `RESP_OKAY;
      arready_o  <= 1'b1;
      rvalid_o   <= 1'b0;
      rdata_o    <= `ZERO32;
      rresp_o    <= `RESP_OKAY;
      awaddr_q   <= 8'h00;
      wdata_q    <= `ZERO32;
      wstrb_q    <= 4'h0;
      count_q    <= `ZERO32;
      pcount_q   <= `ZERO32;
      prescale_q <= `ZERO32;
      ctrl_q     <= `CTRL_RST;
      action_q   <= {AW{1'b0}};
      outcfg_q   <= `OUTCFG_RST;
      release_q  <= {NMATCH{1'b0}};
      status_q   <= {NMATCH{1'b0}};
      mask_q     <= {NMATCH{1'b0}};
      level_q    <= {NOUT{1'b0}};
      pwm_o      <= {NOUT{1'b0}};
      irq_o      <= 1'b0;
      for (k = 0; k < NMATCH; k = k + 1) begin
        shadow_q[k] <= `ZERO32;
      end
    end else begin
      // Counter and prescaler
      // A limit written below the running prescaler count makes it wrap through the full range
      if (ctrl_q[`CTRL_CLEAR]) begin
        count_q  <= `ZERO32;
        pcount_q <= `ZERO32;
      end else if (tick) begin
        pcount_q <= `ZERO32; // RQ13
        count_q  <= reset_hit ? `ZERO32 : count_q + `ONE32; // RQ1 RQ3
      end else if (run) begin
        pcount_q <= pcount_q + `ONE32; // RQ1
      end
      if (stop_hit) begin
        ctrl_q[`CTRL_RUN] <= 1'b0; // RQ9
      end
      if (period_ev) begin
        release_q <= release_q & ~load; // RQ12
      end
      status_q <= status_d;
      level_q  <= level_d;
      pwm_o    <= pwm_d;
      irq_o    <= |(status_d & mask_q);

      // Write channels are taken in either order and joined here
      if (awvalid_i && awready_o) begin
        awaddr_q  <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        wdata_q  <= wdata_i;
        wstrb_q  <= wstrb_i;
        wready_o <= 1'b0;
      end
      if (do_write) begin
        bvalid_o <= 1'b1;
        bresp_o  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ok && wr_off >= `OFF_MATCH0 && wr_off <= `OFF_MATCH6) begin
          shadow_q[mr_wr_idx] <= merge(shadow_q[mr_wr_idx], wdata_q, wstrb_q); // RQ10
        end else if (wr_ok) begin
          case (wr_off)
            `OFF_CTRL: begin
              ctrl_q <= ctrl_m[`CTRL_W-1:0] & `CTRL_WMASK;
            end
            `OFF_COUNT: begin
              count_q <= merge(count_q, wdata_q, wstrb_q);
            end
            `OFF_PRESCALE: begin
              prescale_q <= merge(prescale_q, wdata_q, wstrb_q); // RQ1
            end
            `OFF_PCOUNT: begin
              pcount_q <= merge(pcount_q, wdata_q, wstrb_q);
            end
            `OFF_ACTION: begin
              action_q <= action_m[AW-1:0]; // RQ9
            end
            `OFF_OUTCFG: begin
              outcfg_q <= outcfg_m[`OUTCFG_W-1:0];
            end
            `OFF_RELEASE: begin
              // A release written during a period load keeps its new bits and drops the loaded ones
              release_q <= (release_q & ~release_clr) | wdata_q[NMATCH-1:0]; // RQ10 RQ12
            end
            `OFF_MASK: begin
              mask_q <= wdata_q[NMATCH-1:0];
            end
            default: begin
              mask_q <= mask_q;
            end
          endcase
        end
      end
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end

      // Read answers in the cycle after the address is taken
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        rvalid_o  <= 1'b1;
        rdata_o   <= rd_val;
        rresp_o   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

endmodule // pwm_timer

// [verif/pwm_timer_props.sv]
// Checker of the register bus handshakes of the PWM timer
`timescale 1ns/1ns
module pwm_timer_props (
  input wire        clk_i,
  input wire        rst_i,
  input wire        awvalid_i,
  input wire        awready_o,
  input wire        wvalid_i,
  input wire        wready_o,
  input wire [1:0]  bresp_o,
  input wire        bvalid_o,
  input wire        bready_i,
  input wire        arvalid_i,
  input wire        arready_o,
  input wire [31:0] rdata_o,
  input wire        rvalid_o,
  input wire        rready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_write_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o)
    else $error("write answer late");
  a_aw_taken: assert property (awvalid_i && awready_o |=> !awready_o)
    else $error("write address taken twice");
  a_w_taken: assert property (wvalid_i && wready_o |=> !wready_o)
    else $error("write data taken twice");
  a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write answer dropped");
  a_bvalid_done: assert property (bvalid_o && bready_i |=> !bvalid_o && awready_o && wready_o)
    else $error("write answer not closed");
  a_write_busy: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write taken while busy");
  a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("read answer late");
  a_rdata_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read answer dropped");
  a_rvalid_done: assert property (rvalid_o && rready_i |=> !rvalid_o && arready_o)
    else $error("read answer not closed");
  a_read_busy: assert property (rvalid_o |-> !arready_o)
    else $error("read taken while busy");
endmodule // pwm_timer_props

// [verif/testbench.sv]
// Self-checking bench of the match-based PWM timer
`timescale 1ns/1ns
`include "pwm_timer_consts.vh"
module testbench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  awaddr_i = 8'h00;
  reg  [7:0]  araddr_i = 8'h00;
  reg  [31:0] wdata_i = 32'h0;
  reg  [3:0]  wstrb_i = 4'hF;
  reg         awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  wire        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  wire [1:0]  bresp_o, rresp_o;
  wire [31:0] rdata_o;
  wire [5:0]  pwm_o;
  reg  [31:0] rd_q;
  reg  [1:0]  rresp_q;
  reg  [1:0]  bresp_q;
  reg  [7:0]  h1, h2, rc;
  reg  [71:0] rows [0:5];
  integer     error_cnt = 0, n_compared = 0, i;

  always #20 clk_i = ~clk_i;

  pwm_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .pwm_o(pwm_o), .irq_o(irq_o));

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Address and data offered together, each dropped on its own handshake
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      do begin
        @(posedge clk_i);
        if (awready_o === 1'b1) awvalid_i <= 1'b0;
        if (wready_o === 1'b1) wvalid_i <= 1'b0;
      end while (bvalid_o !== 1'b1);
      bresp_q = bresp_o;
      bready_i <= 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge clk_i);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do begin
        @(posedge clk_i);
        if (arready_o === 1'b1) arvalid_i <= 1'b0;
      end while (rvalid_o !== 1'b1);
      rd_q = rdata_o;
      rresp_q = rresp_o;
      rready_i <= 1'b0;
    end
  endtask

  // Window of 200 clocks is a whole number of cycles, so counts do not depend on phase
  task meas;
    reg p;
    begin
      h1 = 8'h00;
      h2 = 8'h00;
      rc = 8'h00;
      p = pwm_o[0];
      repeat (200) begin
        @(negedge clk_i);
        h1 = h1 + {7'h0, pwm_o[0]};
        h2 = h2 + {7'h0, pwm_o[1]};
        if (pwm_o[0] && !p) rc = rc + 8'h01;
        p = pwm_o[0];
      end
    end
  endtask

  // Row: prescale, match1, match2, outcfg, ctrl, high count ch1, high count ch2, rises ch1
  task run_row(input [71:0] r);
    begin
      wr(`OFF_CTRL, 32'h2);
      wr(`OFF_PRESCALE, {24'h0, r[71:64]});
      wr(`OFF_MATCH0, 32'h9);
      wr(`OFF_MATCH0 + 8'h04, {24'h0, r[63:56]});
      wr(`OFF_MATCH0 + 8'h08, {24'h0, r[55:48]});
      wr(`OFF_OUTCFG, {16'h0, r[47:32]});
      wr(`OFF_CTRL, {24'h0, r[31:24]});
      repeat (40) @(posedge clk_i);
      meas;
    end
  endtask

  task irq_chk(input e);
    begin
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq_o}, {31'h0, e});
    end
  endtask

  task final_report;
    begin
      $display("Errors %0d, comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    final_report;
  end

  initial begin
    rows[0] = 72'h00_04_07_0600_09_64_A0_14;
    rows[1] = 72'h01_04_07_0600_09_64_A0_0A;
    rows[2] = 72'h00_02_06_0604_09_3C_50_14;
    rows[3] = 72'h00_06_02_0604_09_8C_78_14;
    rows[4] = 72'h00_09_07_0200_09_00_00_00;
    rows[5] = 72'h00_04_07_0600_01_00_00_00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFF_CTRL);
    chk(rd_q, 32'h0);
    rd(8'h40);
    chk({30'h0, rresp_q}, {30'h0, `RESP_SLVERR});
    for (i = 0; i < 6; i = i + 1) begin
      run_row(rows[i]);
      chk({24'h0, h1}, {24'h0, rows[i][23:16]});
      chk({24'h0, h2}, {24'h0, rows[i][15:8]});
      chk({24'h0, rc}, {24'h0, rows[i][7:0]});
    end
    // Shadow change while running must not reach the output before release
    run_row(rows[0]);
    wr(`OFF_MATCH0 + 8'h04, 32'h7);
    repeat (40) @(posedge clk_i);
    meas;
    chk({24'h0, h1}, 32'h64);
    wr(`OFF_RELEASE, 32'h2);
    repeat (40) @(posedge clk_i);
    rd(`OFF_RELEASE);
    chk(rd_q, 32'h0);
    meas;
    chk({24'h0, h1}, 32'hA0);
    wr(`OFF_MASK, 32'h1);
    wr(`OFF_ACTION, 32'h5);
    // The next period match may lie a whole cycle away
    repeat (12) @(posedge clk_i);
    irq_chk(1'b1);
    rd(`OFF_CTRL);
    chk(rd_q, 32'h8);
    rd(`OFF_COUNT);
    chk(rd_q, 32'h0);
    chk({26'h0, pwm_o}, 32'h3);
    wr(`OFF_MASK, 32'h0);
    irq_chk(1'b0);
    wr(`OFF_MASK, 32'h1);
    irq_chk(1'b1);
    wr(`OFF_STATUS, 32'h1);
    irq_chk(1'b0);
    wr(8'h44, 32'h1);
    chk({30'h0, bresp_q}, {30'h0, `RESP_SLVERR});
    // Reset while the timer is stopped drops the held outputs and reopens the bus
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({26'h0, pwm_o}, 32'h0);
    chk({29'h0, awready_o, wready_o, arready_o}, 32'h7);
    chk({31'h0, irq_o}, 32'h0);
    rst_i <= 1'b0;
    // Plain timer: match 1 resets, stops and flags
    wr(`OFF_MATCH0 + 8'h04, 32'h3);
    wr(`OFF_ACTION, 32'h38);
    wr(`OFF_CTRL, 32'h1);
    repeat (12) @(posedge clk_i);
    rd(`OFF_COUNT);
    chk(rd_q, 32'h0);
    rd(`OFF_STATUS);
    chk(rd_q, 32'h2);
    rd(`OFF_CTRL);
    chk(rd_q, 32'h0);
    chk({26'h0, pwm_o}, 32'h0);
    final_report;
  end
endmodule // testbench

bind pwm_timer pwm_timer_props u_props (.clk_i(clk_i), .rst_i(rst_i), .awvalid_i(awvalid_i),
  .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
  .bready_i(bready_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .rready_i(rready_i));
